// file: src/obm_regs.svh
/*
  constants of the boot mirror: otp layout, header offsets, marker values.
  assumes byte offsets into the otp; word index is offset divided by four.
*/
`ifndef OBM_REGS_SVH
`define OBM_REGS_SVH

`define OBM_OTP_WORDS 14'h2000
`define OBM_OTP_AW 13
`define OBM_HDR_DBG_OFS 15'h7ffc
`define OBM_HDR_LEN_OFS 15'h7ff8
`define OBM_HDR_FLAG2_OFS 15'h7f04
`define OBM_HDR_FLAG1_OFS 15'h7f00
`define OBM_DBG_OFF 8'haa
`define OBM_FLAG1_VAL 32'h1234a5a5
`define OBM_FLAG2_VAL 32'ha5a51234
`define OBM_REMAP_ADDR 32'h00000000

`endif

// file: src/obm_pkg.sv
/*
  types of the boot mirror.
  assumes the constants header is included by users that need numbers.
*/
package obm_pkg;
  typedef struct packed {
    logic [12:0] addr;
    logic [31:0] data;
  } obm_word_s;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_DBG   = 7'h02,
    ST_LEN   = 7'h04,
    ST_FLAG1 = 7'h08,
    ST_FLAG2 = 7'h10,
    ST_COPY  = 7'h20,
    ST_DONE  = 7'h40
  } obm_state_e;
endpackage : obm_pkg

// file: src/obm_fifo.sv
/*
  small synchronous fifo with valid/ready on both sides.
  assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module obm_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = cnt != (AW+1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];

  always_comb begin
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule : obm_fifo

// file: src/obm_loader.sv
/*
  boot mirror: on boot or wake in normal mode, read the otp header, then copy
  the counted words from otp into system ram and release the cpu into ram, when an application is present.
  assumes the whole block runs on the fast rc clock while the crystal settles,
  an otp read port with one-cycle registered read data, and a ram write port
  with a ready handshake.
*/
//
// Functional notes
// - every boot or wake in normal mode with an application present copies otp code to ram, no software
// - after copy, code runs from ram via soft reset or jump
// - copy runs on the fast rc clock while fast crystal settles
// - development mode maps address zero to loaded memory, cpu resets there
// - otp is 8k words of 32 bits, word addressed
// - copy length in words comes from header word below the top
// - top header word: 0xaa disables debug pins, otherwise enabled
// - application present only when both flag words match their markers
`timescale 1ns/1ps
`include "obm_regs.svh"
module obm_loader #(
  parameter int RAM_AW = 14
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic boot_req,
  input wire logic dev_mode,
  input wire logic use_jump,
  input wire logic fast_crystal_osc_ok,
  output logic [12:0] otp_addr,
  output logic otp_rd,
  input wire logic [31:0] otp_rdata,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  output logic ram_we,
  input wire logic ram_ready,
  output logic fast_rc_osc_en,
  output logic busy,
  output logic done,
  output logic app_present,
  output logic dbg_pins_en,
  output logic cpu_soft_rst,
  output logic cpu_jump,
  output logic remap_ram
);
  // ----------------------------------------------------------------------
  // header fetch and copy sequencer
  // ----------------------------------------------------------------------
  obm_pkg::obm_state_e state, next_state;
  logic [13:0] len, next_len;
  logic [13:0] rd_cnt, next_rd_cnt;
  logic [13:0] wr_cnt, next_wr_cnt;
  logic rd_pend, next_rd_pend;
  logic flag1_ok, next_flag1_ok;
  logic next_app_present, next_dbg_pins_en, next_done, next_busy;
  logic next_otp_rd, next_rc_en, next_soft_rst, next_jump;
  logic [12:0] next_otp_addr;
  obm_pkg::obm_word_s f_in, f_out;
  logic f_in_valid, f_in_ready, f_out_valid, f_pop;

  assign f_in.addr = rd_cnt[12:0] - 13'h1;
  assign f_in.data = otp_rdata;
  assign f_in_valid = rd_pend && state == obm_pkg::ST_COPY;

  always_comb begin
    next_state = state;
    next_len = len;
    next_rd_cnt = rd_cnt;
    next_rd_pend = 1'b0;
    next_flag1_ok = flag1_ok;
    next_app_present = app_present;
    next_dbg_pins_en = dbg_pins_en;
    next_done = done;
    next_busy = busy;
    next_otp_rd = 1'b0;
    next_otp_addr = otp_addr;
    next_rc_en = fast_rc_osc_en;
    next_soft_rst = 1'b0;
    next_jump = 1'b0;
    unique case (state)
      obm_pkg::ST_IDLE: begin
        if (boot_req && !dev_mode) begin
          next_state = obm_pkg::ST_DBG;
          next_busy = 1'b1;
          next_done = 1'b0;
          next_rc_en = 1'b1;
          next_otp_rd = 1'b1;
          next_otp_addr = 13'(`OBM_HDR_DBG_OFS >> 2);
        end
      end
      obm_pkg::ST_DBG: begin
        if (!otp_rd) begin
          next_dbg_pins_en = otp_rdata[7:0] != `OBM_DBG_OFF;
          next_state = obm_pkg::ST_LEN;
          next_otp_rd = 1'b1;
          next_otp_addr = 13'(`OBM_HDR_LEN_OFS >> 2);
        end
      end
      obm_pkg::ST_LEN: begin
        if (!otp_rd) begin
          // length clamps to the array size
          next_len = otp_rdata > 32'(`OBM_OTP_WORDS) ? `OBM_OTP_WORDS
                     : otp_rdata[13:0];
          next_state = obm_pkg::ST_FLAG1;
          next_otp_rd = 1'b1;
          next_otp_addr = 13'(`OBM_HDR_FLAG1_OFS >> 2);
        end
      end
      obm_pkg::ST_FLAG1: begin
        if (!otp_rd) begin
          next_flag1_ok = otp_rdata == `OBM_FLAG1_VAL;
          next_state = obm_pkg::ST_FLAG2;
          next_otp_rd = 1'b1;
          next_otp_addr = 13'(`OBM_HDR_FLAG2_OFS >> 2);
        end
      end
      obm_pkg::ST_FLAG2: begin
        if (!otp_rd) begin
          next_app_present = flag1_ok && otp_rdata == `OBM_FLAG2_VAL;
          next_rd_cnt = '0;
          next_state = next_app_present ? obm_pkg::ST_COPY : obm_pkg::ST_DONE;
        end
      end
      obm_pkg::ST_COPY: begin
        // one read in flight; the fifo stalls further reads when full
        if (!rd_pend && !otp_rd && rd_cnt < len && f_in_ready) begin
          next_otp_rd = 1'b1;
          next_otp_addr = rd_cnt[12:0];
          next_rd_cnt = rd_cnt + 14'h1;
        end
        next_rd_pend = otp_rd;
        if (wr_cnt == len && !f_out_valid && !rd_pend && !otp_rd) begin
          next_state = obm_pkg::ST_DONE;
        end
      end
      obm_pkg::ST_DONE: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        if (fast_crystal_osc_ok) begin
          next_rc_en = 1'b0;
        end
        if (app_present && !done) begin
          next_soft_rst = !use_jump;
          next_jump = use_jump;
        end
        next_state = obm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= obm_pkg::ST_IDLE;
      len <= '0;
      rd_cnt <= '0;
      rd_pend <= 1'b0;
      flag1_ok <= 1'b0;
      app_present <= 1'b0;
      dbg_pins_en <= 1'b1;
      done <= 1'b0;
      busy <= 1'b0;
      otp_rd <= 1'b0;
      otp_addr <= '0;
      fast_rc_osc_en <= 1'b1;
      cpu_soft_rst <= 1'b0;
      cpu_jump <= 1'b0;
    end else begin
      state <= next_state;
      len <= next_len;
      rd_cnt <= next_rd_cnt;
      rd_pend <= next_rd_pend;
      flag1_ok <= next_flag1_ok;
      app_present <= next_app_present;
      dbg_pins_en <= next_dbg_pins_en;
      done <= next_done;
      busy <= next_busy;
      otp_rd <= next_otp_rd;
      otp_addr <= next_otp_addr;
      fast_rc_osc_en <= next_rc_en;
      cpu_soft_rst <= next_soft_rst;
      cpu_jump <= next_jump;
    end
  end

  // ----------------------------------------------------------------------
  // buffered ram write side
  // ----------------------------------------------------------------------
  obm_fifo #(
    .WIDTH($bits(obm_pkg::obm_word_s)),
    .DEPTH(4)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(f_in),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_out_valid),
    .out_ready(f_pop)
  );

  logic next_ram_we;
  logic [RAM_AW-1:0] next_ram_addr;
  logic [31:0] next_ram_wdata;
  logic next_remap;

  assign f_pop = f_out_valid && (!ram_we || ram_ready);

  always_comb begin
    next_ram_we = ram_we && !ram_ready;
    next_ram_addr = ram_addr;
    next_ram_wdata = ram_wdata;
    next_wr_cnt = (ram_we && ram_ready) ? wr_cnt + 14'h1 : wr_cnt;
    if (state == obm_pkg::ST_FLAG2) begin
      next_wr_cnt = '0;
    end
    if (f_pop) begin
      next_ram_we = 1'b1;
      next_ram_addr = RAM_AW'(f_out.addr);
      next_ram_wdata = f_out.data;
    end
    next_remap = dev_mode;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_we <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= '0;
      wr_cnt <= '0;
      remap_ram <= 1'b0;
    end else begin
      ram_we <= next_ram_we;
      ram_addr <= next_ram_addr;
      ram_wdata <= next_ram_wdata;
      wr_cnt <= next_wr_cnt;
      remap_ram <= next_remap;
    end
  end
endmodule : obm_loader

// file: sim/obm_loader_checker.sv
/* assertions on the ports of the boot mirror loader.
   assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/1ps
module obm_loader_checker #(
  parameter int RAM_AW = 14
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic boot_req,
  input wire logic dev_mode,
  input wire logic use_jump,
  input wire logic [12:0] otp_addr,
  input wire logic otp_rd,
  input wire logic [31:0] otp_rdata,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_ready,
  input wire logic fast_rc_osc_en,
  input wire logic busy,
  input wire logic done,
  input wire logic app_present,
  input wire logic dbg_pins_en,
  input wire logic cpu_soft_rst,
  input wire logic cpu_jump,
  input wire logic remap_ram
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    boot_req && !busy && !dev_mode;
  endsequence
  sequence s_hdr;
    otp_rd && otp_addr == 13'h1fff ##2 otp_rd && otp_addr == 13'h1ffe
      ##2 otp_rd && otp_addr == 13'h1fc0 ##2 otp_rd && otp_addr == 13'h1fc1;
  endsequence
  sequence s_dbg_off;
    otp_rd && otp_addr == 13'h1fff ##1 otp_rdata[7:0] == 8'haa;
  endsequence
  property p_hdr; s_take |=> s_hdr; endproperty
  property p_rd_gap; otp_rd |=> !otp_rd; endproperty
  property p_we_hold;
    ram_we && !ram_ready |=> ram_we && $stable(ram_addr) && $stable(ram_wdata);
  endproperty
  property p_done; $rose(done) |-> !ram_we && !otp_rd && !busy; endproperty
  property p_cpu; (cpu_soft_rst || cpu_jump) |-> app_present ##1 !(cpu_soft_rst || cpu_jump);
  endproperty
  property p_kind; (cpu_soft_rst || cpu_jump) |-> cpu_jump == use_jump; endproperty
  property p_remap; 1'b1 |=> remap_ram == $past(dev_mode); endproperty
  property p_dev; dev_mode && !busy |=> !busy && !otp_rd; endproperty
  property p_dbg; s_dbg_off |-> ##[1:4] !dbg_pins_en; endproperty
  property p_rc; busy |-> fast_rc_osc_en; endproperty
  a_hdr: assert property (p_hdr) else $error("header reads out of order");
  a_rd_gap: assert property (p_rd_gap) else $error("otp reads too close");
  a_we_hold: assert property (p_we_hold) else $error("ram write dropped");
  a_done: assert property (p_done) else $error("done before last write");
  a_cpu: assert property (p_cpu) else $error("bad cpu release pulse");
  a_kind: assert property (p_kind) else $error("wrong release kind");
  a_remap: assert property (p_remap) else $error("remap not following mode");
  a_dev: assert property (p_dev) else $error("boot taken in dev mode");
  a_dbg: assert property (p_dbg) else $error("debug pins not disabled");
  a_rc: assert property (p_rc) else $error("rc clock off while busy");
endmodule : obm_loader_checker

bind obm_loader obm_loader_checker #(.RAM_AW(RAM_AW)) u_chk (.clk, .sys_rst, .boot_req,
  .dev_mode, .use_jump, .otp_addr, .otp_rd, .otp_rdata, .ram_addr, .ram_wdata, .ram_we,
  .ram_ready, .fast_rc_osc_en, .busy, .done, .app_present, .dbg_pins_en, .cpu_soft_rst,
  .cpu_jump, .remap_ram);

// file: sim/obm_mem_model.sv
/* behavioural otp array and system ram behind the boot mirror.
   assumes reads answer one cycle after otp_rd, writes land on ram_we && ram_ready. */
`timescale 1ns/1ps
`include "obm_regs.svh"
module obm_mem_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic slow,
  input wire logic flag_ok,
  input wire logic [7:0] hdr_dbg,
  input wire logic [31:0] hdr_len,
  input wire logic [12:0] otp_addr,
  input wire logic otp_rd,
  output logic [31:0] otp_rdata,
  input wire logic [13:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  input wire logic ram_we,
  output logic ram_ready
);
  logic [31:0] ram [0:63];
  logic [1:0] tick = 2'h0;
  int wr_count;
  int bad;
  // 8k words, header in the top 64 words
  function automatic logic [31:0] otp_word(input logic [12:0] a);
    if (a == 13'h1fff) return {4{hdr_dbg}};
    if (a == 13'h1ffe) return hdr_len;
    if (a == 13'h1fc0) return flag_ok ? `OBM_FLAG1_VAL : 32'h0;
    if (a == 13'h1fc1) return `OBM_FLAG2_VAL;
    // fixed image from word zero, vectors first, blank word above, no patches
    if (a < hdr_len) return 32'h5a000000 | a;
    return 32'h0;
  endfunction : otp_word
  assign ram_ready = !slow || tick == 2'h3;
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    otp_rdata <= otp_rd ? otp_word(otp_addr) : ~otp_rdata;
    if (clr) begin
      wr_count <= 0;
      bad <= 0;
    end else if (ram_we && ram_ready) begin
      ram[ram_addr[5:0]] <= ram_wdata;
      if (int'(ram_addr) != wr_count) bad <= bad + 1;
      wr_count <= wr_count + 1;
    end
  end
endmodule : obm_mem_model

// file: sim/testbench.sv
/* self-checking bench of the boot mirror loader.
   assumes the memory model and the bound checker. */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic boot_req = 1'b0;
  logic dev_mode = 1'b0;
  logic use_jump = 1'b0;
  logic fast_crystal_osc_ok = 1'b0;
  logic clr = 1'b1;
  logic slow = 1'b1;
  logic flag_ok = 1'b1;
  logic [7:0] hdr_dbg = 8'h00;
  logic [31:0] hdr_len = 32'h0;
  logic [12:0] otp_addr;
  logic otp_rd, ram_we, ram_ready, fast_rc_osc_en, busy, done, app_present;
  logic dbg_pins_en, cpu_soft_rst, cpu_jump, remap_ram;
  logic [31:0] otp_rdata, ram_wdata;
  logic [13:0] ram_addr;
  int fail_count = 0;
  int num_checks = 0;
  int n_rst = 0;
  int n_jump = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (cpu_soft_rst === 1'b1) n_rst++;
    if (cpu_jump === 1'b1) n_jump++;
  end
  obm_loader #(.RAM_AW(14)) u_dut (.clk, .sys_rst, .boot_req, .dev_mode, .use_jump,
    .fast_crystal_osc_ok, .otp_addr, .otp_rd, .otp_rdata, .ram_addr, .ram_wdata, .ram_we,
    .ram_ready, .fast_rc_osc_en, .busy, .done, .app_present, .dbg_pins_en, .cpu_soft_rst,
    .cpu_jump, .remap_ram);
  obm_mem_model u_mem (.clk, .clr, .slow, .flag_ok, .hdr_dbg, .hdr_len, .otp_addr, .otp_rd,
    .otp_rdata, .ram_addr, .ram_wdata, .ram_we, .ram_ready);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic boot(input logic [31:0] len, input logic [7:0] dbg, input logic ok);
    int i;
    hdr_len <= len;
    hdr_dbg <= dbg;
    flag_ok <= ok;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    boot_req <= 1'b1;
    @(posedge clk);
    boot_req <= 1'b0;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(posedge clk);
    if (i == 4000) begin
      fail_count++;
      conclude();
    end
    repeat (4) @(posedge clk);
  endtask : boot
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_copy(input logic [31:0] len, input logic [7:0] dbg, input logic jmp);
    int r0 = n_rst;
    int j0 = n_jump;
    use_jump <= jmp;
    boot(len, dbg, 1'b1);
    check("app", app_present, 32'h1);
    check("done", done, 32'h1);
    check("busy", busy, 32'h0);
    check("dbg", dbg_pins_en, {31'h0, dbg != 8'haa});
    check("count", u_mem.wr_count, len);
    check("order", u_mem.bad, 32'h0);
    for (int i = 0; i < len; i++) check("ram", u_mem.ram[i], 32'h5a000000 | i);
    check("rst", n_rst - r0, {31'h0, !jmp});
    check("jump", n_jump - j0, {31'h0, jmp});
    check("rc", fast_rc_osc_en, {31'h0, !fast_crystal_osc_ok});
  endtask : t_copy
  task automatic t_no_app();
    int r0 = n_rst + n_jump;
    boot(32'h3, 8'h00, 1'b0);
    check("app", app_present, 32'h0);
    check("count", u_mem.wr_count, 32'h0);
    check("pulse", n_rst + n_jump, r0);
  endtask : t_no_app
  task automatic t_reset();
    hdr_len <= 32'h20;
    hdr_dbg <= 8'h00;
    flag_ok <= 1'b1;
    boot_req <= 1'b1;
    @(posedge clk);
    boot_req <= 1'b0;
    repeat (20) @(posedge clk);
    check("busy", busy, 32'h1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    check("busy", busy, 32'h0);
    check("done", done, 32'h0);
    check("we", ram_we, 32'h0);
    check("rd", otp_rd, 32'h0);
    check("dbg", dbg_pins_en, 32'h1);
    check("rc", fast_rc_osc_en, 32'h1);
    check("app", app_present, 32'h0);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask : t_reset
  task automatic t_dev();
    dev_mode <= 1'b1;
    repeat (2) @(posedge clk);
    boot_req <= 1'b1;
    @(posedge clk);
    boot_req <= 1'b0;
    repeat (10) @(posedge clk);
    check("remap", remap_ram, 32'h1);
    check("busy", busy, 32'h0);
    dev_mode <= 1'b0;
    repeat (2) @(posedge clk);
    check("remap", remap_ram, 32'h0);
  endtask : t_dev
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_copy(32'hc, 8'h00, 1'b0);
    slow <= 1'b0;
    fast_crystal_osc_ok <= 1'b1;
    t_copy(32'h8, 8'haa, 1'b1);
    t_no_app();
    t_reset();
    t_copy(32'h10, 8'h00, 1'b0);
    t_dev();
    conclude();
  end
endmodule : testbench
